// ### verilog/fsr_regs.svh
`ifndef FSR_REGS_SVH
`define FSR_REGS_SVH

// Register offsets on the control port
`define FSR_OFS_LATCHED_B    8'h3b
`define FSR_OFS_LIVE_A       8'h3c
`define FSR_OFS_CHAN_SUMMARY 8'h3d
`define FSR_OFS_INPUT_ONE    8'h3e

// Reset values
`define FSR_RST_LATCHED_B    8'h00
`define FSR_RST_LIVE_A       8'h00
`define FSR_RST_CHAN_SUMMARY 8'h00
`define FSR_RST_INPUT_ONE    8'h00
`define FSR_RD_UNMAPPED      8'h00

// Latched event register bit positions
`define FSR_LAT_ANALOG_UP    7
`define FSR_LAT_ANALOG_LOW   6
`define FSR_LAT_VOICE_UP     5
`define FSR_LAT_VOICE_DOWN   4
`define FSR_LAT_BIAS_SHORT   3
`define FSR_LAT_BIAS_HI_CUR  2
`define FSR_LAT_BIAS_LO_CUR  1
`define FSR_LAT_BIAS_OVERV   0

// Live event register bit positions
`define FSR_LIVE_CLK_ERR     7
`define FSR_LIVE_LOOP_LOCK   6
`define FSR_LIVE_BOOST_OT    5
`define FSR_LIVE_BOOST_OC    4
`define FSR_LIVE_BOOST_COND  3

// Channel summary bit positions
`define FSR_SUM_CH1          7
`define FSR_SUM_CH2          6
`define FSR_SUM_BAT_SHORT    3

// Synchroniser depth
`define FSR_SYNC_STAGES      2

`endif

// ### verilog/fsr_pkg.sv
`default_nettype none

package fsr_pkg;

  typedef logic [7:0] fsr_byte_t;
  typedef logic [7:0] fsr_addr_t;

endpackage : fsr_pkg

`default_nettype wire

// ### verilog/fsr_sync.sv
`timescale 1ns/100ps
`default_nettype none

module fsr_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             reset_n,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // Two flip-flop synchroniser
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end
    else
    begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;

endmodule : fsr_sync

`default_nettype wire

// ### verilog/fsr_fault_status.sv
`timescale 1ns/100ps
`default_nettype none
`include "fsr_regs.svh"

// Functional notes
// - Latched event register at 0x3B, resets zero
// - Bit 7 latches analog upper threshold
// - Bit 6 latches analog lower threshold
// - Bits 5/4 latch voice power up/down
// - Bits 3/0 latch bias short/overvoltage
// - Bits 2/1 latch bias high/low current
// - Live register 0x3C: clock error, lock
// - Bits 5..3 boost temperature, current, boost_mo_condition
// - Live bits 2..0 reserved, read zero
// - Summary 0x3D bit 7: channel 1 faults
// - Summary bit 6: channel 2 faults
// - Summary bit 3: battery short fault
// - Channel 1 live register at 0x3E
// - Channel 1 bits: open, shorted, gnd, bias, battery
module fsr_fault_status
  import fsr_pkg::*;
(
  // Clock and reset
  input  wire logic      mclk,
  input  wire logic      reset_n,
  // Control port read access
  input  wire logic      rd_en,
  input  wire fsr_addr_t rd_addr,
  output logic           rd_valid,
  output fsr_byte_t      rd_data,
  // Latched event sources
  input  wire logic      analog_upper_fault,
  input  wire logic      analog_lower_fault,
  input  wire logic      voice_power_up,
  input  wire logic      voice_power_down,
  input  wire logic      bias_short_fault,
  input  wire logic      bias_high_current,
  input  wire logic      bias_low_current,
  input  wire logic      bias_overvoltage,
  // Live event sources
  input  wire logic      clock_error,
  input  wire logic      loop_lock,
  input  wire logic      boost_over_temp,
  input  wire logic      boost_over_current,
  input  wire logic      boost_mo_condition,
  // Input fault sources
  input  wire fsr_byte_t input_one_faults,
  input  wire fsr_byte_t input_two_faults,
  input  wire logic      battery_short_fault
);

  localparam int SRC_W = 30;

  logic [SRC_W-1:0] src_async;
  logic [SRC_W-1:0] src_sync;
  fsr_byte_t        lat_src_s;
  fsr_byte_t        lat_set;
  logic [4:0]       live_src_s;
  fsr_byte_t        ch1_s;
  fsr_byte_t        ch2_s;
  logic             bat_s;

  fsr_byte_t        lat_reg;
  fsr_byte_t        lat_next;
  fsr_byte_t        live_a_reg;
  fsr_byte_t        live_a_next;
  fsr_byte_t        sum_reg;
  fsr_byte_t        sum_next;
  fsr_byte_t        in1_reg;
  fsr_byte_t        in1_next;
  fsr_byte_t        rd_data_reg;
  fsr_byte_t        rd_data_next;
  logic             rd_valid_reg;
  logic             rd_valid_next;
  logic             lat_rd_clr;

  // Any bit set in a byte
  function automatic logic any_set(input fsr_byte_t v);
    any_set = |v;
  endfunction : any_set

  assign src_async = {analog_upper_fault, analog_lower_fault, voice_power_up, voice_power_down,
                      bias_short_fault, bias_high_current, bias_low_current,
                      bias_overvoltage, clock_error, loop_lock, boost_over_temp,
                      boost_over_current, boost_mo_condition, input_one_faults,
                      input_two_faults, battery_short_fault};

  // Detector outputs come from the analog domain
  fsr_sync #(
    .WIDTH (SRC_W)
  ) u_sync (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .async_in (src_async),
    .sync_out (src_sync)
  );

  assign lat_src_s  = src_sync[29:22];
  assign live_src_s = src_sync[21:17];
  assign ch1_s      = src_sync[16:9];
  assign ch2_s      = src_sync[8:1];
  assign bat_s      = src_sync[0];

  assign lat_rd_clr = rd_en && (rd_addr == `FSR_OFS_LATCHED_B);

  always_comb
  begin
    lat_set = 8'h00;
    lat_set[`FSR_LAT_ANALOG_UP]   = lat_src_s[7];
    lat_set[`FSR_LAT_ANALOG_LOW]  = lat_src_s[6];
    lat_set[`FSR_LAT_VOICE_UP]    = lat_src_s[5];
    lat_set[`FSR_LAT_VOICE_DOWN]  = lat_src_s[4];
    lat_set[`FSR_LAT_BIAS_SHORT]  = lat_src_s[3];
    lat_set[`FSR_LAT_BIAS_OVERV]  = lat_src_s[0];
    lat_set[`FSR_LAT_BIAS_HI_CUR] = lat_src_s[2];
    lat_set[`FSR_LAT_BIAS_LO_CUR] = lat_src_s[1];
    lat_next = (lat_rd_clr ? 8'h00 : lat_reg) | lat_set;
    live_a_next = `FSR_RST_LIVE_A;
    live_a_next[`FSR_LIVE_CLK_ERR]   = live_src_s[4];
    live_a_next[`FSR_LIVE_LOOP_LOCK] = live_src_s[3];
    live_a_next[`FSR_LIVE_BOOST_OT]  = live_src_s[2];
    live_a_next[`FSR_LIVE_BOOST_OC]  = live_src_s[1];
    live_a_next[`FSR_LIVE_BOOST_COND] = live_src_s[0];
    sum_next = `FSR_RST_CHAN_SUMMARY;
    sum_next[`FSR_SUM_CH1]       = any_set(ch1_s);
    sum_next[`FSR_SUM_CH2]       = any_set(ch2_s);
    sum_next[`FSR_SUM_BAT_SHORT] = bat_s;
    in1_next = ch1_s;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lat_reg    <= `FSR_RST_LATCHED_B;
      live_a_reg <= `FSR_RST_LIVE_A;
      sum_reg    <= `FSR_RST_CHAN_SUMMARY;
      in1_reg    <= `FSR_RST_INPUT_ONE;
    end
    else
    begin
      lat_reg    <= lat_next;
      live_a_reg <= live_a_next;
      sum_reg    <= sum_next;
      in1_reg    <= in1_next;
    end
  end

  // Read mux, registered
  always_comb
  begin
    rd_valid_next = rd_en;
    rd_data_next  = rd_data_reg;
    if (rd_en)
    begin
      case (rd_addr)
        `FSR_OFS_LATCHED_B:    rd_data_next = lat_reg;
        `FSR_OFS_LIVE_A:       rd_data_next = live_a_reg;
        `FSR_OFS_CHAN_SUMMARY: rd_data_next = sum_reg;
        `FSR_OFS_INPUT_ONE:    rd_data_next = in1_reg;
        default:               rd_data_next = `FSR_RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_valid_reg <= 1'b0;
      rd_data_reg  <= `FSR_RD_UNMAPPED;
    end
    else
    begin
      rd_valid_reg <= rd_valid_next;
      rd_data_reg  <= rd_data_next;
    end
  end

  assign rd_valid = rd_valid_reg;
  assign rd_data  = rd_data_reg;

  AST_LAT_READ: assert property (@(posedge mclk) disable iff (!reset_n)
    lat_rd_clr |=> (rd_valid && rd_data == $past(lat_reg)))
    else $error("Latched read returned wrong data");

  AST_ANALOG_UP: assert property (@(posedge mclk) disable iff (!reset_n)
    analog_upper_fault ##2 1'b1 |=> lat_reg[`FSR_LAT_ANALOG_UP])
    else $error("Upper threshold not latched");

  AST_ANALOG_LOW: assert property (@(posedge mclk) disable iff (!reset_n)
    lat_src_s[`FSR_LAT_ANALOG_LOW] |=> lat_reg[`FSR_LAT_ANALOG_LOW])
    else $error("Lower threshold not latched");

  AST_VOICE: assert property (@(posedge mclk) disable iff (!reset_n)
    (lat_src_s[5:4] != 2'b00) |=> ((lat_reg[5:4] & $past(lat_src_s[5:4])) == $past(lat_src_s[5:4])))
    else $error("Voice event not latched");

  AST_BIAS_SC_OV: assert property (@(posedge mclk) disable iff (!reset_n)
    (lat_src_s[3] || lat_src_s[0]) |=> ((lat_reg[3] || !$past(lat_src_s[3])) && (lat_reg[0] || !$past(lat_src_s[0]))))
    else $error("Bias short or overvoltage not latched");

  AST_BIAS_CUR: assert property (@(posedge mclk) disable iff (!reset_n)
    (lat_src_s[2:1] != 2'b00) |=> ((lat_reg[2:1] & $past(lat_src_s[2:1])) == $past(lat_src_s[2:1])))
    else $error("Bias current fault not latched");

  AST_LAT_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
    !lat_rd_clr |=> ((lat_reg & $past(lat_reg)) == $past(lat_reg)))
    else $error("Latched flag lost without read");

  AST_LAT_CLEAR: assert property (@(posedge mclk) disable iff (!reset_n)
    (lat_rd_clr && lat_src_s == 8'h00) |=> (lat_reg == 8'h00))
    else $error("Latched flags not cleared by read");

  AST_LIVE_A: assert property (@(posedge mclk) disable iff (!reset_n)
    1'b1 |=> (live_a_reg[7:3] == $past(live_src_s)))
    else $error("Live event bits wrong");

  AST_LIVE_FOLLOW: assert property (@(posedge mclk) disable iff (!reset_n)
    $fell(live_src_s[2]) |=> !live_a_reg[`FSR_LIVE_BOOST_OT])
    else $error("Live bit held after source cleared");

  AST_LIVE_RSVD: assert property (@(posedge mclk) disable iff (!reset_n)
    live_a_reg[2:0] == 3'h0)
    else $error("Live reserved bits nonzero");

  AST_SUM_CH1: assert property (@(posedge mclk) disable iff (!reset_n)
    1'b1 |=> (sum_reg[`FSR_SUM_CH1] == $past(|ch1_s)))
    else $error("Channel one summary wrong");

  AST_SUM_CH2: assert property (@(posedge mclk) disable iff (!reset_n)
    1'b1 |=> (sum_reg[`FSR_SUM_CH2] == $past(|ch2_s)))
    else $error("Channel two summary wrong");

  AST_SUM_BAT: assert property (@(posedge mclk) disable iff (!reset_n)
    1'b1 |=> (sum_reg[`FSR_SUM_BAT_SHORT] == $past(bat_s)))
    else $error("Battery short summary wrong");

  AST_SUM_RSVD: assert property (@(posedge mclk) disable iff (!reset_n)
    (sum_reg & 8'h37) == 8'h00)
    else $error("Summary reserved bits nonzero");

  AST_IN1: assert property (@(posedge mclk) disable iff (!reset_n)
    1'b1 |=> (in1_reg == $past(ch1_s)))
    else $error("Channel one live bits wrong");

  AST_IN1_READ: assert property (@(posedge mclk) disable iff (!reset_n)
    (rd_en && rd_addr == `FSR_OFS_INPUT_ONE) |=> (rd_data == $past(in1_reg)))
    else $error("Channel one read wrong");

endmodule : fsr_fault_status

`default_nettype wire

// ### tb/fsr_testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "fsr_regs.svh"

module testbench
  import fsr_pkg::*;
  ;
  logic       mclk;
  logic       reset_n;
  logic       rd_en;
  fsr_addr_t  rd_addr;
  logic       rd_valid;
  fsr_byte_t  rd_data;
  fsr_byte_t  lat_src;
  logic [4:0] live_src;
  fsr_byte_t  in1;
  fsr_byte_t  in2;
  logic       bat;
  fsr_byte_t  lat_model;
  int         err_count;
  int         checks;
  fsr_addr_t  adr [6];

  fsr_fault_status dut (
    .mclk               (mclk),
    .reset_n            (reset_n),
    .rd_en              (rd_en),
    .rd_addr            (rd_addr),
    .rd_valid           (rd_valid),
    .rd_data            (rd_data),
    .analog_upper_fault (lat_src[7]),
    .analog_lower_fault (lat_src[6]),
    .voice_power_up     (lat_src[5]),
    .voice_power_down   (lat_src[4]),
    .bias_short_fault   (lat_src[3]),
    .bias_high_current  (lat_src[2]),
    .bias_low_current   (lat_src[1]),
    .bias_overvoltage   (lat_src[0]),
    .clock_error        (live_src[4]),
    .loop_lock          (live_src[3]),
    .boost_over_temp    (live_src[2]),
    .boost_over_current (live_src[1]),
    .boost_mo_condition (live_src[0]),
    .input_one_faults   (in1),
    .input_two_faults   (in2),
    .battery_short_fault(bat)
  );

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test

  task automatic check_byte(string what, fsr_byte_t exp, fsr_byte_t got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check_byte

  task automatic check_bit(string what, logic exp, logic got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  // One read, answer checked half a cycle after the taking edge
  task automatic rd(fsr_addr_t a, fsr_byte_t exp, string what);
    @(negedge mclk);
    check_bit("rd_valid idle", 1'b0, rd_valid);
    rd_en   = 1'b1;
    rd_addr = a;
    @(negedge mclk);
    check_bit("rd_valid", 1'b1, rd_valid);
    check_byte(what, exp, rd_data);
    rd_en = 1'b0;
  endtask : rd

  // Latched read returns model, then clears all but held sources
  task automatic rd_lat();
    rd(`FSR_OFS_LATCHED_B, lat_model, "latched");
    lat_model = lat_src;
  endtask : rd_lat

  task automatic settle();
    repeat (4) @(negedge mclk);
    lat_model = lat_model | lat_src;
  endtask : settle

  task automatic do_reset();
    reset_n = 1'b0;
    repeat (2) @(negedge mclk);
    reset_n   = 1'b1;
    lat_model = 8'h00;
  endtask : do_reset

  initial
  begin
    #(25 * 20000);
    err_count++;
    finish_test();
  end

  initial
  begin
    rd_en     = 1'b0;
    rd_addr   = 8'h00;
    lat_src   = 8'h00;
    live_src  = 5'h00;
    in1       = 8'h00;
    in2       = 8'h00;
    bat       = 1'b0;
    reset_n   = 1'b0;
    err_count = 0;
    checks    = 0;
    lat_model = 8'h00;
    adr       = '{8'h3b, 8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h00};
    void'($urandom(32'h51e0));
    do_reset();
    foreach (adr[i])
      rd(adr[i], 8'h00, "reset value");
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      lat_src = 8'h01 << i;
      settle();
      lat_src = 8'h00;
      settle();
      rd_lat();
      rd_lat();
    end
    $display("test latched bits done");
    for (int i = 0; i < 20; i++)
    begin
      lat_src = fsr_byte_t'($urandom);
      settle();
      lat_src = fsr_byte_t'($urandom);
      settle();
      rd_lat();
      rd_lat();
    end
    lat_src = 8'hff;
    settle();
    lat_src = 8'h00;
    do_reset();
    rd_lat();
    $display("test latched random done");
    for (int i = 0; i < 20; i++)
    begin
      live_src = 5'($urandom);
      in1      = fsr_byte_t'($urandom);
      in2      = (i % 3 == 0) ? 8'h00 : fsr_byte_t'($urandom);
      bat      = 1'($urandom);
      if (i % 4 == 0)
        in1 = 8'h00;
      settle();
      rd(`FSR_OFS_LIVE_A, {live_src, 3'b000}, "live");
      rd(`FSR_OFS_LIVE_A, {live_src, 3'b000}, "live again");
      rd(`FSR_OFS_CHAN_SUMMARY, {|in1, |in2, 2'b00, bat, 3'b000}, "summary");
      rd(`FSR_OFS_INPUT_ONE, in1, "input one");
      rd(8'h40, `FSR_RD_UNMAPPED, "unmapped");
    end
    $display("test live done");
    finish_test();
  end
endmodule : testbench

`default_nettype wire
